// >>> design/brcl_ctrl.v
// What this block does
// - low-side on during commutation body-diode conduction
// - start after margin, stop when demag ends
// - low-side on in high-side-only PWM off
// - async mode, with sync also enabled, cuts low-side near zero current
// - trip when summed current crosses reference
// - reference at half AVDD disables limit
// - tripped high side off until next cycle
// - recirculation bit selects brake or high-Z
// - ignore trip briefly after PWM goes active
// - internal clock re-enables at 100% duty
// - register variant selects slow or fast clock
// - pin variant uses fixed slow clock
// - supply undervoltage: bridge off, logic off, flag
// - regulator undervoltage: fault pin, flag kept
// - pump undervoltage: fault pin, bridge off, flag
// - overvoltage acts only when enabled
// - demag needs both rectify enables set
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "brcl_consts.vh"

module brcl_ctrl #(
    parameter REG_VARIANT = 1,
    parameter RECLK_SLOW_CYC =
        (`BRCL_T_RECLK_SLOW_NS * `BRCL_SYS_CLK_MHZ) / 1000,
    parameter RECLK_FAST_CYC =
        (`BRCL_T_RECLK_FAST_NS * `BRCL_SYS_CLK_MHZ) / 1000
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_ce,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire [2:0] i_pwm_hi,
    input wire [2:0] i_pwm_lo,
    input wire [2:0] i_demag_cmp,
    input wire [2:0] i_zero_cur_cmp,
    input wire i_limit_cmp,
    input wire i_limit_ref_at_half,
    input wire i_vm_uv,
    input wire i_avdd_uv,
    input wire i_regulator_undervoltage_flag,
    input wire i_pump_uv,
    input wire i_vm_ov,
    input wire i_sleep_pin_n,
    output reg [2:0] o_gate_hi,
    output reg [2:0] o_gate_lo,
    output wire o_fault_pin_n_o,
    output reg o_fault_pin_n_oe_n,
    output reg o_logic_enable,
    output wire o_irq
);

    // ****************************************
    // derived cycle counts
    // ****************************************
    // rounded up so a short margin or blank never ends early
    localparam integer MARGIN_N =
        (`BRCL_T_MARGIN_NS * `BRCL_SYS_CLK_MHZ + 999) / 1000;
    localparam integer COMM_MAX_N =
        (`BRCL_T_COMM_MAX_NS * `BRCL_SYS_CLK_MHZ) / 1000;
    localparam integer BLANK_N =
        (`BRCL_T_BLANK_NS * `BRCL_SYS_CLK_MHZ + 999) / 1000;
    localparam integer RECLK_SLOW_N = RECLK_SLOW_CYC;
    localparam integer RECLK_FAST_N = RECLK_FAST_CYC;
    // counters are sized for the documented counts; larger values are cut
    localparam [11:0] MARGIN_CYC = MARGIN_N[11:0];
    localparam [11:0] COMM_MAX_CYC = COMM_MAX_N[11:0];
    localparam [11:0] BLANK_CYC = BLANK_N[11:0];
    localparam [15:0] RECLK_SLOW = RECLK_SLOW_N[15:0];
    localparam [15:0] RECLK_FAST = RECLK_FAST_N[15:0];

    localparam [1:0] SR_IDLE = 2'h0;
    localparam [1:0] SR_MARGIN = 2'h1;
    localparam [1:0] SR_ON = 2'h2;

    localparam SYNC_W = 20;
    // sleep input idles high; resetting it low would fake a wake-up edge
    localparam [SYNC_W-1:0] SYNC_IDLE = 20'h80000;

    // ****************************************
    // input synchronisers
    // ****************************************
    wire [SYNC_W-1:0] async_in;
    reg [SYNC_W-1:0] sync_a;
    reg [SYNC_W-1:0] sync_b;
    assign async_in = {i_sleep_pin_n, i_vm_ov, i_pump_uv, i_regulator_undervoltage_flag, i_avdd_uv,
                       i_vm_uv, i_limit_ref_at_half, i_limit_cmp, i_zero_cur_cmp,
                       i_demag_cmp, i_pwm_lo, i_pwm_hi};

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
        end else if (i_ce) begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    wire [2:0] pwm_hi = sync_b[2:0];
    wire [2:0] pwm_lo = sync_b[5:3];
    wire [2:0] demag = sync_b[8:6];
    wire [2:0] zero_cur = sync_b[11:9];
    wire limit_cmp = sync_b[12];
    wire limit_off = sync_b[13];
    wire vm_uv = sync_b[14];
    wire avdd_uv = sync_b[15];
    wire regulator_undervoltage_flag = sync_b[16];
    wire pump_uv = sync_b[17];
    wire vm_ov = sync_b[18];
    wire sleep_n = sync_b[19];

    // edges come from the synchronised copies, never the raw pins
    reg [2:0] pwm_hi_prev;
    reg sleep_n_prev;
    wire [2:0] hi_rise = pwm_hi & ~pwm_hi_prev;
    wire [2:0] hi_fall = ~pwm_hi & pwm_hi_prev;
    wire sleep_pulse = sleep_n & ~sleep_n_prev;

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pwm_hi_prev <= 3'h0;
            sleep_n_prev <= 1'b1;
        end else if (i_ce) begin
            pwm_hi_prev <= pwm_hi;
            sleep_n_prev <= sleep_n;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    reg [`BRCL_CTRL_W-1:0] ctrl;
    reg [`BRCL_FLT_W-1:0] fault_flag;
    reg [`BRCL_EVT_W-1:0] irq_stat;
    reg [`BRCL_EVT_W-1:0] irq_en;
    reg ack;

    // shared by the read mux and the write strobes
    function sel;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    wire req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~(ack & i_ce);
    wire wr_go = i_avs_write & ack & i_ce;
    wire clr_fault = wr_go & sel(i_avs_address, `BRCL_OFS_FAULT_CLR)
                     & i_avs_writedata[`BRCL_FLT_CLR_BIT];
    wire irq_clr_go = wr_go & sel(i_avs_address, `BRCL_OFS_IRQ_CLR);

    // one wait cycle, then the answer; readdata is settled at that edge
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ack <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else if (i_ce) begin
            ack <= req & ~ack;
            if (i_avs_read & ~ack) begin
                o_avs_readdata <= 32'h00000000;
                if (sel(i_avs_address, `BRCL_OFS_CTRL))
                    o_avs_readdata[`BRCL_CTRL_W-1:0] <= ctrl;
                if (sel(i_avs_address, `BRCL_OFS_FAULT_STAT))
                    o_avs_readdata[`BRCL_FLT_W-1:0] <= fault_flag;
                if (sel(i_avs_address, `BRCL_OFS_IRQ_STAT))
                    o_avs_readdata[`BRCL_EVT_W-1:0] <= irq_stat;
                if (sel(i_avs_address, `BRCL_OFS_IRQ_EN))
                    o_avs_readdata[`BRCL_EVT_W-1:0] <= irq_en;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl <= `BRCL_CTRL_RST;
            irq_en <= `BRCL_EVT_RST;
        end else if (i_ce & wr_go) begin
            if (sel(i_avs_address, `BRCL_OFS_CTRL))
                ctrl <= i_avs_writedata[`BRCL_CTRL_W-1:0];
            if (sel(i_avs_address, `BRCL_OFS_IRQ_EN))
                irq_en <= i_avs_writedata[`BRCL_EVT_W-1:0];
        end
    end

    wire sync_en = ctrl[`BRCL_CTRL_SYNC_EN];
    wire async_en = ctrl[`BRCL_CTRL_ASYNC_EN];
    wire recirc_brake = ctrl[`BRCL_CTRL_RECIRC];
    wire ov_en = ctrl[`BRCL_CTRL_OV_EN];
    wire demag_ok = sync_en & async_en;

    // ****************************************
    // supply supervision
    // ****************************************
    wire supply_uv = vm_uv | avdd_uv;
    wire ov_act = vm_ov & ov_en;
    wire bridge_ok = ~supply_uv & ~pump_uv & ~ov_act & sleep_n;
    wire fault_live = avdd_uv | regulator_undervoltage_flag | pump_uv | ov_act;
    wire [`BRCL_FLT_W-1:0] flt_set = {ov_act, pump_uv, regulator_undervoltage_flag, supply_uv};
    wire flt_clr = clr_fault | sleep_pulse;

    // a fault still present wins over a clear in the same cycle
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            fault_flag <= `BRCL_FLT_RST;
            o_fault_pin_n_oe_n <= 1'b1;
            o_logic_enable <= 1'b0;
        end else if (i_ce) begin
            fault_flag <= flt_set | (fault_flag & {`BRCL_FLT_W{~flt_clr}});
            o_fault_pin_n_oe_n <= ~fault_live;
            o_logic_enable <= ~supply_uv;
        end
    end
    // open drain: only the enable moves, the driven level is always low
    assign o_fault_pin_n_o = 1'b0;

    // ****************************************
    // current limit
    // ****************************************
    reg [11:0] blank_cnt;
    reg [15:0] reclk_cnt;
    reg limit_hold;
    wire fast_sel = (REG_VARIANT != 0) & ctrl[`BRCL_CTRL_RECLK_FAST];
    wire [15:0] reclk_period = fast_sel ? RECLK_FAST : RECLK_SLOW;
    wire reclk_tick = (reclk_cnt >= reclk_period - 16'h0001);
    wire blanking = (blank_cnt != 12'h000);
    // the edge that starts a cycle is blanked too, so a trip latched just
    // before it cannot outlive the new cycle
    wire trip = limit_cmp & ~limit_off & ~blanking & ~(|hi_rise);
    wire new_cycle = (|hi_rise) | reclk_tick;

    // the internal clock restarts on every rising high-side PWM edge, so it fires only when no such edge comes within one period, as at 100% duty
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            blank_cnt <= 12'h000;
            reclk_cnt <= 16'h0000;
            limit_hold <= 1'b0;
        end else if (i_ce) begin
            if (|hi_rise)
                blank_cnt <= BLANK_CYC;
            else if (blanking)
                blank_cnt <= blank_cnt - 12'h001;
            if ((|hi_rise) | reclk_tick)
                reclk_cnt <= 16'h0000;
            else
                reclk_cnt <= reclk_cnt + 16'h0001;
            if (trip)
                limit_hold <= 1'b1;
            else if (new_cycle)
                limit_hold <= 1'b0;
        end
    end

    // ****************************************
    // interrupt events
    // ****************************************
    reg [`BRCL_FLT_W-1:0] flt_prev;
    reg limit_prev;
    wire [`BRCL_EVT_W-1:0] evt = {limit_hold & ~limit_prev, fault_flag & ~flt_prev};

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            flt_prev <= `BRCL_FLT_RST;
            limit_prev <= 1'b0;
            irq_stat <= `BRCL_EVT_RST;
        end else if (i_ce) begin
            flt_prev <= fault_flag;
            limit_prev <= limit_hold;
            irq_stat <= evt | (irq_stat & ~({`BRCL_EVT_W{irq_clr_go}}
                        & i_avs_writedata[`BRCL_EVT_W-1:0]));
        end
    end
    assign o_irq = |(irq_stat & irq_en);

    // ****************************************
    // per-phase rectification and gate drive
    // ****************************************
    wire [2:0] next_gate_hi;
    wire [2:0] next_gate_lo;
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
            reg [1:0] sr_state;
            reg [11:0] sr_cnt;
            reg aar_cut;
            wire sr_allow = demag_ok & sync_en;
            wire lo_cmd = pwm_lo[ph];
            wire sr_lo = (sr_state == SR_ON);
            wire lo_norm = (lo_cmd & ~aar_cut) | sr_lo;

            always @(posedge i_sys_clk) begin
                if (i_rst) begin
                    sr_state <= SR_IDLE;
                    sr_cnt <= 12'h000;
                end else if (i_ce) begin
                    case (sr_state)
                        SR_IDLE: begin
                            if (sr_allow & hi_fall[ph] & ~lo_cmd) begin
                                sr_state <= SR_MARGIN;
                                sr_cnt <= 12'h000;
                            end
                        end
                        SR_MARGIN: begin
                            if (pwm_hi[ph] | lo_cmd | ~sr_allow) begin
                                sr_state <= SR_IDLE;
                            end else if (sr_cnt >= MARGIN_CYC - 12'h001) begin
                                sr_state <= demag[ph] ? SR_ON : SR_IDLE;
                                sr_cnt <= 12'h000;
                            end else begin
                                sr_cnt <= sr_cnt + 12'h001;
                            end
                        end
                        SR_ON: begin
                            if (pwm_hi[ph] | lo_cmd | ~sr_allow | ~demag[ph]
                                | (sr_cnt >= COMM_MAX_CYC - 12'h001)) begin
                                sr_state <= SR_IDLE;
                            end else begin
                                sr_cnt <= sr_cnt + 12'h001;
                            end
                        end
                        default: begin
                            sr_state <= SR_IDLE;
                        end
                    endcase
                end
            end

            // cut stays until the low-side command ends, avoiding re-closing
            always @(posedge i_sys_clk) begin
                if (i_rst) begin
                    aar_cut <= 1'b0;
                end else if (i_ce) begin
                    if (~lo_cmd)
                        aar_cut <= 1'b0;
                    else if (demag_ok & async_en & zero_cur[ph])
                        aar_cut <= 1'b1;
                end
            end

            assign next_gate_hi[ph] = bridge_ok & pwm_hi[ph] & ~limit_hold;
            assign next_gate_lo[ph] = limit_hold ? (bridge_ok & recirc_brake)
                                                 : (bridge_ok & lo_norm & ~pwm_hi[ph]);
        end
    endgenerate

    // ****************************************
    // gate registers
    // ****************************************
    // one block for all legs keeps a single driver per output
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_gate_hi <= 3'h0;
            o_gate_lo <= 3'h0;
        end else if (i_ce) begin
            o_gate_hi <= next_gate_hi;
            o_gate_lo <= next_gate_lo;
        end
    end

endmodule

`default_nettype wire

// >>> design/brcl_consts.vh
`ifndef BRCL_CONSTS_VH
`define BRCL_CONSTS_VH

// ****************************************
// clock
// ****************************************
`define BRCL_SYS_CLK_MHZ 125

// ****************************************
// timing, in nanoseconds
// ****************************************
`define BRCL_T_MARGIN_NS 200
`define BRCL_T_COMM_MAX_NS 20000
`define BRCL_T_BLANK_NS 1000
`define BRCL_T_RECLK_SLOW_NS 50000
`define BRCL_T_RECLK_FAST_NS 25000

// ****************************************
// register byte offsets
// ****************************************
`define BRCL_OFS_CTRL 8'h00
`define BRCL_OFS_FAULT_STAT 8'h04
`define BRCL_OFS_FAULT_CLR 8'h08
`define BRCL_OFS_IRQ_STAT 8'h0C
`define BRCL_OFS_IRQ_EN 8'h10
`define BRCL_OFS_IRQ_CLR 8'h14

// ****************************************
// control field positions and reset value
// ****************************************
`define BRCL_CTRL_SYNC_EN 0
`define BRCL_CTRL_ASYNC_EN 1
`define BRCL_CTRL_RECIRC 2
`define BRCL_CTRL_OV_EN 3
`define BRCL_CTRL_RECLK_FAST 4
`define BRCL_CTRL_W 5
`define BRCL_CTRL_RST 5'h00

// ****************************************
// fault and event bit positions
// ****************************************
`define BRCL_FLT_POR 0
`define BRCL_FLT_BUCK 1
`define BRCL_FLT_PUMP 2
`define BRCL_FLT_OV 3
`define BRCL_EVT_LIMIT 4
`define BRCL_FLT_W 4
`define BRCL_EVT_W 5
`define BRCL_FLT_CLR_BIT 0
`define BRCL_FLT_RST 4'h1
`define BRCL_EVT_RST 5'h00

`endif

// >>> tb/brcl_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module brcl_ctrl_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_vm_uv,
    input wire logic i_avdd_uv,
    input wire logic i_regulator_undervoltage_flag,
    input wire logic i_pump_uv,
    input wire logic i_vm_ov,
    input wire logic [2:0] o_gate_hi,
    input wire logic [2:0] o_gate_lo,
    input wire logic o_fault_pin_n_oe_n,
    input wire logic o_logic_enable
);
    // ****************************************
    // shadow of the overvoltage enable bit
    // ****************************************
    logic ov_en;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ov_en <= 1'b0;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00) begin
            ov_en <= i_avs_writedata[3];
        end
    end
    // four samples cover the two sync stages plus the output register
    uv_lockout_a: assert property ((i_vm_uv || i_avdd_uv)[*4] |=>
        !o_logic_enable && o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
        else $error("bridge or logic alive in supply undervoltage");
    avdd_pin_a: assert property (i_avdd_uv[*4] |=> !o_fault_pin_n_oe_n)
        else $error("fault pin released in avdd undervoltage");
    buck_pin_a: assert property ((i_regulator_undervoltage_flag && !i_vm_uv && !i_avdd_uv)[*4] |=>
        !o_fault_pin_n_oe_n && o_logic_enable)
        else $error("buck undervoltage response wrong");
    pump_off_a: assert property (i_pump_uv[*4] |=>
        !o_fault_pin_n_oe_n && o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
        else $error("pump undervoltage response wrong");
    ov_active_a: assert property ((i_vm_ov && ov_en)[*4] |=>
        !o_fault_pin_n_oe_n && o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
        else $error("enabled overvoltage response wrong");
    pin_idle_a: assert property
        ((!i_avdd_uv && !i_regulator_undervoltage_flag && !i_pump_uv && !(i_vm_ov && ov_en))[*4]
        |=> o_fault_pin_n_oe_n)
        else $error("fault pin low without cause");
    wait_one_a: assert property
        ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer later than one wait cycle");
    unmapped_zero_a: assert property
        (i_avs_read && !o_avs_waitrequest && i_avs_address > 8'h14 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind brcl_ctrl brcl_ctrl_chk u_chk (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_vm_uv,
    .i_avdd_uv, .i_regulator_undervoltage_flag, .i_pump_uv, .i_vm_ov, .o_gate_hi, .o_gate_lo,
    .o_fault_pin_n_oe_n, .o_logic_enable);
`default_nettype wire

// >>> tb/brcl_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module brcl_mcu_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_hi_cmd,
    input wire logic [2:0] i_lo_cmd,
    input wire logic i_fault_wire,
    output var logic [2:0] o_pwm_hi,
    output var logic [2:0] o_pwm_lo,
    output var logic o_fault_seen
);
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pwm_hi <= 3'h0;
            o_pwm_lo <= 3'h0;
            o_fault_seen <= 1'b0;
        end else begin
            o_pwm_hi <= i_hi_cmd;
            // never both switches of one leg at once
            o_pwm_lo <= i_lo_cmd & ~i_hi_cmd;
            o_fault_seen <= ~i_fault_wire;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_bridge_rectify_current_limit_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_rectify_current_limit_ctrl;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic wreq, fo, foe_n, len, irq, fseen;
    logic [2:0] hi_cmd = 3'h0;
    logic [2:0] lo_cmd = 3'h0;
    logic [2:0] pwm_hi, pwm_lo, ghi, glo, ghi_pin;
    logic [2:0] demag = 3'h0;
    logic [2:0] zc = 3'h0;
    logic lim = 1'b0;
    logic half = 1'b1;
    logic slp_n = 1'b1;
    logic [4:0] flt = 5'h00;
    logic [4:0] fv [6] = '{5'h04, 5'h08, 5'h10, 5'h10, 5'h02, 5'h01};
    integer seed = 32'h315D;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    // open drain with pull-up
    wire fwire = foe_n ? 1'b1 : fo;
    always #4 clk = ~clk;
    brcl_ctrl #(.REG_VARIANT(1), .RECLK_SLOW_CYC(400), .RECLK_FAST_CYC(200)) uut (
        .i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pwm_hi(pwm_hi),
        .i_pwm_lo(pwm_lo), .i_demag_cmp(demag), .i_zero_cur_cmp(zc), .i_limit_cmp(lim),
        .i_limit_ref_at_half(half), .i_vm_uv(flt[0]), .i_avdd_uv(flt[1]),
        .i_regulator_undervoltage_flag(flt[2]), .i_pump_uv(flt[3]), .i_vm_ov(flt[4]), .i_sleep_pin_n(slp_n),
        .o_gate_hi(ghi), .o_gate_lo(glo), .o_fault_pin_n_o(fo),
        .o_fault_pin_n_oe_n(foe_n), .o_logic_enable(len), .o_irq(irq));
    brcl_mcu_model mcu (.i_clk(clk), .i_rst(rst), .i_hi_cmd(hi_cmd), .i_lo_cmd(lo_cmd),
        .i_fault_wire(fwire), .o_pwm_hi(pwm_hi), .o_pwm_lo(pwm_lo), .o_fault_seen(fseen));
    // pin-configured variant on the same stimulus: its re-enable clock stays slow
    brcl_ctrl #(.REG_VARIANT(0), .RECLK_SLOW_CYC(400), .RECLK_FAST_CYC(200)) uut_pin (
        .i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(), .o_avs_waitrequest(),
        .i_pwm_hi(pwm_hi), .i_pwm_lo(pwm_lo), .i_demag_cmp(demag), .i_zero_cur_cmp(zc),
        .i_limit_cmp(lim), .i_limit_ref_at_half(half), .i_vm_uv(flt[0]), .i_avdd_uv(flt[1]),
        .i_regulator_undervoltage_flag(flt[2]), .i_pump_uv(flt[3]), .i_vm_ov(flt[4]), .i_sleep_pin_n(slp_n),
        .o_gate_hi(ghi_pin), .o_gate_lo(), .o_fault_pin_n_o(), .o_fault_pin_n_oe_n(),
        .o_logic_enable(), .o_irq());
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        // waitrequest and read data are taken at the rising edge that ends the wait
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        chk("bus_wait", wreq, 0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic [31:0] exp_flag(input logic [4:0] f, input logic en);
        return {28'h0, f[4] & en, f[3], f[2], f[1] | f[0]};
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            final_report;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int k;
        logic en, pl;
        logic [4:0] f;
        logic [4:0] v;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, 8'h04, 0);
        chk("fault_stat_rst", q, 1);
        bus(0, 8'h20, 0);
        chk("unmapped", q, 0);
        for (k = 0; k < 4; k++) begin
            v = $random(seed);
            bus(1, 8'h00, {27'h0, v});
            bus(0, 8'h00, 0);
            chk("ctrl_rw", q, {27'h0, v});
        end
        bus(1, 8'h08, 1);
        bus(0, 8'h04, 0);
        chk("por_clr", q, 0);
        $display("test registers done");
        @(posedge clk);
        hi_cmd <= 3'h7;
        for (k = 0; k < 6; k++) begin
            f = fv[k];
            en = (k == 2);
            pl = f[1] | f[2] | f[3] | (f[4] & en);
            bus(1, 8'h00, {28'h0, en, 3'h0});
            bus(1, 8'h10, {27'h0, {5{k != 0}}});
            bus(1, 8'h14, 32'h1F);
            @(posedge clk);
            flt <= f;
            wt(8);
            chk("gate_hi", ghi, (f[0] | f[1] | f[3] | (f[4] & en)) ? 0 : 7);
            chk("pin_oe_n", foe_n, !pl);
            chk("mcu_fault", fseen, pl);
            chk("logic_en", len, !(f[0] | f[1]));
            if (k < 4) chk("irq", irq, (k != 0) && exp_flag(f, en) != 0);
            @(posedge clk);
            flt <= 5'h00;
            wt(8);
            chk("resume", ghi, 7);
            bus(0, 8'h04, 0);
            chk("flag", q, exp_flag(f, en));
            if (k[0]) begin
                @(posedge clk);
                slp_n <= 1'b0;
                wt(4);
                @(posedge clk);
                slp_n <= 1'b1;
                wt(4);
            end else begin
                bus(1, 8'h08, 1);
            end
            bus(0, 8'h04, 0);
            chk("flag_clr", q, 0);
        end
        $display("test faults done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            hi_cmd <= 3'h0;
            half <= (k == 2);
            bus(1, 8'h00, (k == 0) ? 32'h04 : 32'h10);
            bus(1, 8'h14, 32'h1F);
            @(posedge clk);
            hi_cmd <= 3'h1;
            lim <= 1'b1;
            wt(20);
            chk("blank", ghi, 1);
            wt(130);
            chk("trip_hi", ghi, (k == 2) ? 1 : 0);
            chk("trip_lo", glo, (k == 0) ? 7 : 0);
            chk("irq_pin", irq, k != 2);
            @(posedge clk);
            lim <= 1'b0;
            wt(140);
            chk("reclk_fast", ghi, (k == 0) ? 0 : 1);
            chk("reclk_pin", ghi_pin, (k == 2) ? 1 : 0);
            wt(150);
            chk("reclk_slow", ghi, 1);
            chk("reclk_pin_slow", ghi_pin, 1);
            bus(0, 8'h0C, 0);
            chk("irq_limit", q[4], k != 2);
        end
        $display("test current limit done");
        for (k = 0; k < 2; k++) begin
            bus(1, 8'h00, k ? 32'h01 : 32'h03);
            @(posedge clk);
            hi_cmd <= 3'h1;
            demag <= 3'h1;
            wt(10);
            @(posedge clk);
            hi_cmd <= 3'h0;
            wt(12);
            chk("sr_margin", glo, 0);
            wt(30);
            chk("sr_on", glo, k ? 0 : 1);
            @(posedge clk);
            demag <= 3'h0;
            wt(6);
            chk("sr_stop", glo, 0);
        end
        bus(1, 8'h00, 32'h03);
        @(posedge clk);
        lo_cmd <= 3'h1;
        wt(6);
        chk("aar_on", glo, 1);
        @(posedge clk);
        zc <= 3'h1;
        wt(6);
        chk("aar_cut", glo, 0);
        $display("test rectification done");
        final_report;
    end
endmodule
`default_nettype wire
